// ===== hdl/imu_command_output_config_regs.sv
// command and output-configuration registers of the inertial sensor
//
// How it works
// - not-ready bit high until device operational
// - soft reset bit resets, then self-clears
// - restore bit writes factory defaults, self-clears
// - power-on and soft reset load backup image
// - save bit copies backup registers, self-clears
// - burst content steers burst and streaming records
// - upper content bits include flag through velocity
// - low content bits include gpio, counter, checksum
// - width bits pick 32 or 16 bit words
// - polarity bits invert rate and accel outputs
// - inversion also feeds increment accumulation
// - range bit picks 16 G or 8 G
// - bits 7:4 choose angle increment scale
// - bits 3:0 choose velocity increment scale
// - streaming mode sends record every output period while idle
`timescale 1ns/1ps
`include "imu_regs_cfg.svh"

module imu_command_output_config_regs
  import imu_regs_pkg::*;
#(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter int NV_OP_CYCLES = `NV_OP_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire reg_request_t request,
  input wire logic uart_auto_mode,
  input wire logic [23:0] output_period_cycles,
  input wire logic nv_fault,
  input wire axis_samples_t raw_samples,
  output logic [15:0] read_data,
  output logic not_ready,
  output logic nv_save_error,
  output output_config_t config_out,
  output axis_samples_t corrected_samples,
  output logic stream_record
);

  // ********************************
  // state
  // ********************************
  sequence_state_t state;
  backup_image_t live;
  backup_image_t nv_image;
  logic [31:0] wait_count;
  logic [23:0] period_count;
  logic idle;
  logic write_ok;

  assign idle = (state == st_idle);
  // commands and writes are taken only while no operation runs
  assign write_ok = request.write && idle;

  // ********************************
  // sequencer
  // ********************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= st_boot_wait;
      wait_count <= 32'h00000000;
    end else begin
      case (state)
        st_boot_wait: begin
          if (wait_count >= 32'(STARTUP_CYCLES - 1)) begin
            wait_count <= 32'h00000000;
            state <= st_load;
          end else begin
            wait_count <= wait_count + 32'h00000001;
          end
        end
        st_load: begin
          state <= st_idle;
        end
        st_idle: begin
          wait_count <= 32'h00000000;
          if (request.write &&
              request.address == `OFS_GLOBAL_COMMAND) begin
            // soft reset outranks the nonvolatile commands
            if (request.write_data[`BIT_SOFT_RESET]) begin
              state <= st_soft_reset;
            end else if (request.write_data[`BIT_RESTORE]) begin
              state <= st_restore;
            end else if (request.write_data[`BIT_SAVE]) begin
              state <= st_save;
            end
          end
        end
        st_save, st_restore, st_soft_reset: begin
          if (wait_count >= 32'(NV_OP_CYCLES - 1)) begin
            wait_count <= 32'h00000000;
            // a soft reset ends by reloading the backup image
            state <= (state == st_soft_reset) ? st_load : st_idle;
          end else begin
            wait_count <= wait_count + 32'h00000001;
          end
        end
        default: begin
          state <= st_boot_wait;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      not_ready <= 1'b1;
    end else begin
      not_ready <= !(idle || state == st_load);
    end
  end

  // ********************************
  // nonvolatile image
  // ********************************
  // the image is also loaded by a reset: rstn sets it to the factory values,
  // so a saved image does not survive a reset of the block
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nv_image <= {`FACTORY_BURST_CONTENT, `FACTORY_BURST_WIDTH,
                   `FACTORY_AXIS_POLARITY, `FACTORY_RANGE_SELECT};
    end else if (state == st_save &&
                 wait_count >= 32'(NV_OP_CYCLES - 1)) begin
      nv_image <= live;
    end else if (state == st_restore &&
                 wait_count >= 32'(NV_OP_CYCLES - 1)) begin
      nv_image <= {`FACTORY_BURST_CONTENT, `FACTORY_BURST_WIDTH,
                   `FACTORY_AXIS_POLARITY, `FACTORY_RANGE_SELECT};
    end
  end

  // outcome of the last save or restore, for the diagnostic register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nv_save_error <= 1'b0;
    end else if ((state == st_save || state == st_restore) &&
                 wait_count >= 32'(NV_OP_CYCLES - 1)) begin
      nv_save_error <= nv_fault;
    end
  end

  // ********************************
  // backup-target registers
  // ********************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      live <= {`FACTORY_BURST_CONTENT, `FACTORY_BURST_WIDTH,
               `FACTORY_AXIS_POLARITY, `FACTORY_RANGE_SELECT};
    end else if (state == st_load) begin
      live <= nv_image;
    end else if (write_ok) begin
      case (request.address)
        `OFS_BURST_CONTENT: begin
          live.burst_content <=
            request.write_data & `MASK_BURST_CONTENT;
        end
        `OFS_BURST_WIDTH: begin
          live.burst_word_width <=
            request.write_data & `MASK_BURST_WIDTH;
        end
        `OFS_AXIS_POLARITY: begin
          live.axis_polarity <=
            request.write_data & `MASK_AXIS_POLARITY;
        end
        `OFS_RANGE_SELECT: begin
          live.range_select <=
            request.write_data & `MASK_RANGE_SELECT;
        end
        default: begin
          live <= live;
        end
      endcase
    end
  end

  // ********************************
  // read port
  // ********************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      read_data <= 16'h0000;
    end else if (request.read) begin
      case (request.address)
        `OFS_GLOBAL_COMMAND: begin
          read_data <= 16'h0000;
          read_data[`BIT_NOT_READY] <= not_ready;
          read_data[`BIT_SOFT_RESET] <= (state == st_soft_reset);
          read_data[`BIT_RESTORE] <= (state == st_restore);
          read_data[`BIT_SAVE] <= (state == st_save);
        end
        `OFS_BURST_CONTENT: read_data <= live.burst_content;
        `OFS_BURST_WIDTH: read_data <= live.burst_word_width;
        `OFS_AXIS_POLARITY: read_data <= live.axis_polarity;
        `OFS_RANGE_SELECT: read_data <= live.range_select;
        default: read_data <= 16'h0000;
      endcase
    end
  end

  // ********************************
  // configuration to the output path
  // ********************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      config_out <= '0;
    end else begin
      config_out.include_flag <=
        live.burst_content[`CONTENT_FLAG];
      config_out.include_temperature <=
        live.burst_content[`CONTENT_TEMP];
      config_out.include_gyro <=
        live.burst_content[`CONTENT_GYRO];
      config_out.include_accel <=
        live.burst_content[`CONTENT_ACCEL];
      config_out.include_angle_increment <=
        live.burst_content[`CONTENT_ANGLE];
      config_out.include_velocity_increment <=
        live.burst_content[`CONTENT_VELOCITY];
      config_out.include_gpio <=
        live.burst_content[`CONTENT_GPIO];
      config_out.include_counter <=
        live.burst_content[`CONTENT_COUNTER];
      config_out.include_checksum <=
        live.burst_content[`CONTENT_CHECKSUM];
      config_out.temperature_wide <=
        live.burst_word_width[`WIDTH_TEMP];
      config_out.gyro_wide <=
        live.burst_word_width[`WIDTH_GYRO];
      config_out.accel_wide <=
        live.burst_word_width[`WIDTH_ACCEL];
      config_out.angle_increment_wide <=
        live.burst_word_width[`WIDTH_ANGLE];
      config_out.velocity_increment_wide <=
        live.burst_word_width[`WIDTH_VELOCITY];
      config_out.accel_range_16g <=
        live.range_select[`ACCEL_RANGE_BIT];
      config_out.angle_increment_scale <=
        live.range_select[`ANGLE_SCALE_LSB +: `SCALE_WIDTH];
      config_out.velocity_increment_scale <=
        live.range_select[`VELOCITY_SCALE_LSB +: `SCALE_WIDTH];
    end
  end

  // ********************************
  // sign inversion per axis
  // ********************************
  // the increment accumulators take these samples, so the inversion
  // reaches the angle and velocity increments too
  for (genvar axis = 0; axis < `AXIS_COUNT; axis++) begin : g_axis
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        corrected_samples[axis] <= 16'h0000;
      end else if (live.axis_polarity[`POL_LSB + `AXIS_COUNT - 1 - axis])
      begin
        corrected_samples[axis] <= ~raw_samples[axis];
      end else begin
        corrected_samples[axis] <= raw_samples[axis];
      end
    end
  end

  // ********************************
  // streaming pacing
  // ********************************
  // a zero period is treated as one cycle rather than a stuck stream
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      period_count <= 24'h000000;
      stream_record <= 1'b0;
    end else if (!uart_auto_mode || !idle) begin
      period_count <= 24'h000000;
      stream_record <= 1'b0;
    end else if (period_count + 24'h000001 >= output_period_cycles) begin
      period_count <= 24'h000000;
      stream_record <= 1'b1;
    end else begin
      period_count <= period_count + 24'h000001;
      stream_record <= 1'b0;
    end
  end

endmodule

// ===== hdl/imu_regs_cfg.svh
// register offsets, field positions, reset values and timing of the block
`ifndef IMU_REGS_CFG_SVH
`define IMU_REGS_CFG_SVH

// ********************************
// register offsets (byte addresses)
// ********************************
`define OFS_GLOBAL_COMMAND 8'h0A
`define OFS_BURST_CONTENT 8'h0C
`define OFS_BURST_WIDTH 8'h0E
`define OFS_AXIS_POLARITY 8'h10
`define OFS_RANGE_SELECT 8'h12

// ********************************
// field positions and masks
// ********************************
`define BIT_NOT_READY 10
`define BIT_SOFT_RESET 7
`define BIT_RESTORE 4
`define BIT_SAVE 3
`define MASK_BURST_CONTENT 16'hFC07
`define MASK_BURST_WIDTH 16'h7C00
`define MASK_AXIS_POLARITY 16'h007E
`define MASK_RANGE_SELECT 16'h01FF
`define POL_LSB 1
`define ACCEL_RANGE_BIT 8
`define ANGLE_SCALE_LSB 4
`define VELOCITY_SCALE_LSB 0
`define SCALE_WIDTH 4
`define CONTENT_FLAG 15
`define CONTENT_TEMP 14
`define CONTENT_GYRO 13
`define CONTENT_ACCEL 12
`define CONTENT_ANGLE 11
`define CONTENT_VELOCITY 10
`define CONTENT_GPIO 2
`define CONTENT_COUNTER 1
`define CONTENT_CHECKSUM 0
`define WIDTH_TEMP 14
`define WIDTH_GYRO 13
`define WIDTH_ACCEL 12
`define WIDTH_ANGLE 11
`define WIDTH_VELOCITY 10
`define AXIS_COUNT 6

// ********************************
// factory defaults of the backup registers
// ********************************
`define FACTORY_BURST_CONTENT 16'h0000
`define FACTORY_BURST_WIDTH 16'h0000
`define FACTORY_AXIS_POLARITY 16'h0000
`define FACTORY_RANGE_SELECT 16'h0000

// ********************************
// timing
// ********************************
`define CLOCK_MHZ 200
`define STARTUP_US 1000
`define NV_OP_US 100
`define STARTUP_CYCLES (`STARTUP_US * `CLOCK_MHZ)
`define NV_OP_CYCLES (`NV_OP_US * `CLOCK_MHZ)

`endif

// ===== hdl/imu_regs_pkg.sv
// types shared by the command and output-configuration register block
package imu_regs_pkg;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] address;
    logic [15:0] write_data;
  } reg_request_t;

  typedef struct packed {
    logic [15:0] burst_content;
    logic [15:0] burst_word_width;
    logic [15:0] axis_polarity;
    logic [15:0] range_select;
  } backup_image_t;

  typedef struct packed {
    logic include_flag;
    logic include_temperature;
    logic include_gyro;
    logic include_accel;
    logic include_angle_increment;
    logic include_velocity_increment;
    logic include_gpio;
    logic include_counter;
    logic include_checksum;
    logic temperature_wide;
    logic gyro_wide;
    logic accel_wide;
    logic angle_increment_wide;
    logic velocity_increment_wide;
    logic accel_range_16g;
    logic [3:0] angle_increment_scale;
    logic [3:0] velocity_increment_scale;
  } output_config_t;

  // axes 0..5: x, y, z angular rate then x, y, z acceleration
  typedef logic [5:0][15:0] axis_samples_t;

  typedef enum logic [2:0] {
    st_boot_wait,
    st_load,
    st_idle,
    st_save,
    st_restore,
    st_soft_reset
  } sequence_state_t;

endpackage

// ===== tb/imu_regs_properties.sv
// port assertions of the command and output-configuration registers
`timescale 1ns/1ps
module imu_regs_properties
  import imu_regs_pkg::*;
#(
  parameter int STARTUP_CYCLES = 20,
  parameter int NV_OP_CYCLES = 10
) (
  input wire logic clock,
  input wire logic rstn,
  input wire reg_request_t request,
  input wire logic uart_auto_mode,
  input wire logic [23:0] output_period_cycles,
  input wire logic nv_fault,
  input wire axis_samples_t raw_samples,
  input wire logic [15:0] read_data,
  input wire logic not_ready,
  input wire logic nv_save_error,
  input wire output_config_t config_out,
  input wire axis_samples_t corrected_samples,
  input wire logic stream_record
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ********************************
  // assertions
  // ********************************
  AST_BOOT_BUSY: assert property ($rose(rstn) |-> not_ready [*8])
    else $error("ready too early after reset");
  AST_CMD_RESERVED: assert property (
    request.read && request.address == 8'h0A
    |=> (read_data & 16'hFB67) == 16'h0000) else $error("command rsvd");
  AST_CONTENT_RESERVED: assert property (
    request.read && request.address == 8'h0C
    |=> (read_data & 16'h03F8) == 16'h0000) else $error("content rsvd");
  AST_WIDTH_RESERVED: assert property (
    request.read && request.address == 8'h0E
    |=> (read_data & 16'h83FF) == 16'h0000) else $error("width rsvd");
  AST_POL_RESERVED: assert property (
    request.read && request.address == 8'h10
    |=> (read_data & 16'hFF81) == 16'h0000) else $error("polarity rsvd");
  AST_RANGE_RESERVED: assert property (
    request.read && request.address == 8'h12
    |=> (read_data & 16'hFE00) == 16'h0000) else $error("range rsvd");
  AST_CONTENT_TO_CONFIG: assert property (
    request.write && !not_ready && request.address == 8'h0C
    |-> ##2 config_out.include_checksum == $past(request.write_data[0], 2))
    else $error("config lag");
  // the first edge after reset still shows the reset value of the samples
  AST_SIGN_FLIP: assert property ($past(rstn) |->
    corrected_samples[0] == $past(raw_samples[0]) ||
    corrected_samples[0] == ~$past(raw_samples[0]))
    else $error("sample not raw nor inverted");
  AST_STREAM_GAP: assert property (
    output_period_cycles > 24'h000001 && stream_record |=> !stream_record)
    else $error("stream pulse too long");
  AST_STREAM_BUSY: assert property (not_ready && $past(not_ready)
    |-> !stream_record) else $error("stream while busy");
endmodule

bind imu_command_output_config_regs imu_regs_properties #(
  .STARTUP_CYCLES(STARTUP_CYCLES), .NV_OP_CYCLES(NV_OP_CYCLES)) chk (
  .clock, .rstn, .request, .uart_auto_mode, .output_period_cycles, .nv_fault,
  .raw_samples, .read_data, .not_ready, .nv_save_error, .config_out,
  .corrected_samples, .stream_record);

// ===== tb/host_link_model.sv
// host controller model issuing register requests to the device
`timescale 1ns/1ps
module host_link_model
  import imu_regs_pkg::*;
(
  input wire logic clock,
  input wire logic [15:0] read_data,
  output reg_request_t request
);
  initial request = '0;
  // ********************************
  // register access
  // ********************************
  task automatic write_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    #1 request = '{write: 1'b1, read: 1'b0, address: a, write_data: v};
    @(posedge clock);
    #1 request = '0;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clock);
    #1 request = '{write: 1'b0, read: 1'b1, address: a, write_data: 16'h0000};
    @(posedge clock);
    #1 request = '0;
    @(posedge clock);
    #1 v = read_data;
  endtask
  // polls the busy flag; bounded so a stuck device cannot hang the host
  task automatic wait_ready(output bit ok);
    logic [15:0] v;
    ok = 1'b0;
    for (int n = 0; n < 100 && !ok; n++) begin
      read_reg(8'h0A, v);
      ok = (v[10] === 1'b0);
    end
  endtask
endmodule

// ===== tb/imu_command_output_config_regs_test.sv
// self-checking bench of the command and output-configuration registers
`timescale 1ns/1ps
module imu_command_output_config_regs_test;
  import imu_regs_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic uart_auto_mode = 1'b0;
  logic [23:0] output_period_cycles = 24'h000004;
  logic nv_fault = 1'b0;
  axis_samples_t raw_samples;
  reg_request_t request;
  logic [15:0] read_data;
  logic not_ready;
  logic nv_save_error;
  logic stream_record;
  output_config_t config_out;
  axis_samples_t corrected_samples;
  logic [7:0] ofs [4] = '{8'h0C, 8'h0E, 8'h10, 8'h12};
  logic [15:0] msk [4] = '{16'hFC07, 16'h7C00, 16'h007E, 16'h01FF};
  int errors = 0;
  int checks = 0;
  int cnt;
  bit ok;
  always #2.5 clock = ~clock;
  // short counts keep boot and nonvolatile waits within a few dozen cycles
  imu_command_output_config_regs #(.STARTUP_CYCLES(20), .NV_OP_CYCLES(10)) uut (
    .clock(clock), .rstn(rstn), .request(request),
    .uart_auto_mode(uart_auto_mode),
    .output_period_cycles(output_period_cycles), .nv_fault(nv_fault),
    .raw_samples(raw_samples), .read_data(read_data), .not_ready(not_ready),
    .nv_save_error(nv_save_error), .config_out(config_out),
    .corrected_samples(corrected_samples), .stream_record(stream_record));
  host_link_model host (.clock(clock), .read_data(read_data),
    .request(request));
  // ********************************
  // helpers
  // ********************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                    input string what);
    logic [15:0] v;
    host.read_reg(a, v);
    cmp({16'h0000, v}, {16'h0000, exp}, what);
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic ready();
    host.wait_ready(ok);
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: busy flag stuck", $time);
      tally_and_finish();
    end
  endtask
  task automatic cmd(input logic [15:0] v);
    host.write_reg(8'h0A, v);
  endtask
  // ********************************
  // sequence
  // ********************************
  initial begin
    for (int n = 0; n < 6; n++) raw_samples[n] = 16'hA501 + 16'(n);
    repeat (6) @(posedge clock);
    #1 rstn = 1'b1;
    cmp(32'(not_ready), 1, "boot busy");
    host.write_reg(8'h0C, 16'hFFFF);
    rd(8'h0A, 16'h0400, "not ready flag");
    ready();
    rd(8'h0A, 16'h0000, "ready flag");
    rd(8'h0C, 16'h0000, "write in boot");
    for (int n = 0; n < 4; n++) begin
      host.write_reg(ofs[n], 16'hFFFF);
      rd(ofs[n], msk[n], "set all");
      host.write_reg(ofs[n], 16'h0000);
      rd(ofs[n], 16'h0000, "clear all");
    end
    rd(8'h20, 16'h0000, "unmapped");
    host.write_reg(8'h0C, 16'hFC07);
    host.write_reg(8'h0E, 16'h7C00);
    host.write_reg(8'h12, 16'h01A5);
    @(posedge clock);
    #1 cmp(32'(config_out), 32'({9'h1FF, 5'h1F, 1'b1, 4'hA, 4'h5}),
           "cfg");
    for (int n = 0; n < 6; n++) begin
      host.write_reg(8'h10, 16'h0040 >> n);
      repeat (2) @(posedge clock);
      #1 cmp({16'h0000, corrected_samples[n]},
             {16'h0000, ~raw_samples[n]}, "inv");
      cmp(32'(corrected_samples[(n + 1) % 6]), 32'(raw_samples[(n + 1) % 6]),
          "plain");
    end
    cmd(16'h0008);
    rd(8'h0A, 16'h0408, "save busy");
    ready();
    rd(8'h0A, 16'h0000, "save done");
    cmp(32'(nv_save_error), 0, "save ok");
    host.write_reg(8'h0C, 16'h0000);
    cmd(16'h0080);
    rd(8'h0A, 16'h0480, "reset busy");
    ready();
    rd(8'h0A, 16'h0000, "reset done");
    rd(8'h0C, 16'hFC07, "reload");
    rd(8'h12, 16'h01A5, "reload");
    nv_fault = 1'b1;
    cmd(16'h0010);
    rd(8'h0A, 16'h0410, "restore busy");
    ready();
    cmp(32'(nv_save_error), 1, "restore fault");
    rd(8'h0C, 16'hFC07, "live kept");
    nv_fault = 1'b0;
    cmd(16'h0080);
    ready();
    rd(8'h0C, 16'h0000, "factory");
    // a sparse pattern catches swapped fields that all-ones would hide
    host.write_reg(8'h0C, 16'h2402);
    host.write_reg(8'h0E, 16'h4800);
    host.write_reg(8'h12, 16'h0035);
    @(posedge clock);
    #1 cmp(32'(config_out), 32'({9'h04A, 5'h12, 1'b0, 4'h3, 4'h5}),
           "cfg sparse");
    uart_auto_mode = 1'b1;
    cnt = 0;
    repeat (40) begin
      @(posedge clock);
      #1 cnt += int'(stream_record);
    end
    cmp(32'(cnt), 10, "stream");
    tally_and_finish();
  end
endmodule
